// ---- core/timer_pkg.sv ----
// constants, field layouts and carrier types of the dual 8-bit timer control block
// assumes an ahb-lite register bus and a counting datapath outside this block
// Behaviour
// - first timer has control, period, pulse-width registers
// - first control register resets to zero
// - clock select codes pick documented source ticks
// - start low stops and clears; high runs
// - mode codes: timer, divider, pwm, cascade
// - cascade needs first mode 011; second picks mode
// - cascade source from first clock select
// - cascade start and preset from second timer
// - timer registers eight bits, reset all ones
// - second timer has same three registers
// - second mode 1xx counts first overflow
package timer_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_A_CTRL   = 8'h1A;
   localparam logic [7:0] IDX_B_CTRL   = 8'h1B;
   localparam logic [7:0] IDX_A_PERIOD = 8'h1C;
   localparam logic [7:0] IDX_A_PW     = 8'h1D;
   localparam logic [7:0] IDX_B_PERIOD = 8'h1E;
   localparam logic [7:0] IDX_B_PW     = 8'h1F;
   localparam logic [7:0] IDX_CONFIG   = 8'h20;
   localparam logic [7:0] IDX_STATUS   = 8'h21;

   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] TREG_RESET  = 8'hFF;
   // clock codes usable in slow and sleep modes: 000, 100, 110, 111
   localparam logic [7:0] SLOW_CLK_MASK = 8'hD1;
   localparam logic [2:0] CLK_FC       = 3'h6;
   localparam logic [2:0] CLK_PIN      = 3'h7;

   typedef enum logic [2:0] {
      MODE_TIMER   = 3'h0,
      MODE_DIVIDER = 3'h1,
      MODE_PWM     = 3'h2,
      MODE_CASCADE = 3'h3
   } mode_e;

   typedef enum logic [1:0] {
      PWR_NORMAL = 2'h0,
      PWR_IDLE   = 2'h1,
      PWR_SLOW   = 2'h3,
      PWR_SLEEP  = 2'h2
   } power_e;

   typedef struct packed {
      logic       flop_preset;
      logic [2:0] clock_select;
      logic       start;
      logic [2:0] mode;
   } ctrl_s;

   typedef struct packed {
      logic       run;
      logic       flop_preset;
      logic       clear;
      logic [2:0] mode;
      logic [7:0] period;
      logic [7:0] pulse_width;
   } timer_cfg_s;
endpackage : timer_pkg

// ---- core/timer_ctrl.sv ----
// control logic for two 8-bit timers, separate or cascaded, on an ahb-lite slave
// assumes hclk is the high-frequency clock; low_freq_tick, pins and overflow are
// synchronous to hclk; the counters themselves sit outside
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module timer_ctrl (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    ce,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire logic [1:0]              power_mode,
   input  wire logic                    low_freq_tick,
   input  wire logic                    timer_a_pin,
   input  wire logic                    timer_b_pin,
   input  wire logic                    timer_a_overflow,
   output logic                         timer_a_tick,
   output logic                         timer_b_tick,
   output timer_pkg::timer_cfg_s        timer_a_cfg,
   output timer_pkg::timer_cfg_s        timer_b_cfg
);
   timer_pkg::ctrl_s timer_a_control;
   timer_pkg::ctrl_s timer_b_control;
   logic [7:0]       timer_a_period;
   logic [7:0]       timer_a_pulse_width;
   logic [7:0]       timer_b_period;
   logic [7:0]       timer_b_pulse_width;
   logic             prescale_source_select;

   // bus data-phase state
   logic             dp_write;
   logic             dp_read;
   logic [29:0]      dp_word;

   // prescaler state
   logic [10:0]      div_cnt;
   logic [2:0]       fs_cnt;
   logic             pin_a_q;
   logic             pin_b_q;

   // ---------------- ahb-lite slave ----------------
   wire addr_take = hsel & hready & htrans[1];
   wire hit_a_ctrl = dp_word == {22'h0, timer_pkg::IDX_A_CTRL};
   wire hit_b_ctrl = dp_word == {22'h0, timer_pkg::IDX_B_CTRL};
   wire hit_a_per  = dp_word == {22'h0, timer_pkg::IDX_A_PERIOD};
   wire hit_a_pw   = dp_word == {22'h0, timer_pkg::IDX_A_PW};
   wire hit_b_per  = dp_word == {22'h0, timer_pkg::IDX_B_PERIOD};
   wire hit_b_pw   = dp_word == {22'h0, timer_pkg::IDX_B_PW};
   wire hit_config = dp_word == {22'h0, timer_pkg::IDX_CONFIG};
   wire hit_status = dp_word == {22'h0, timer_pkg::IDX_STATUS};
   wire wr_en      = ce & dp_write;

   assign hreadyout = ~dp_read;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_word  <= 30'h0;
      end else if (ce) begin
         dp_write <= addr_take & hwrite;
         dp_read  <= addr_take & ~hwrite;
         dp_word  <= addr_take ? haddr[31:2] : dp_word;
      end
   end

   // ---------------- source clock ticks ----------------
   wire low_power = (power_mode == timer_pkg::PWR_SLOW) | (power_mode == timer_pkg::PWR_SLEEP);
   wire fc2       = div_cnt[0];
   wire fc8       = &div_cnt[2:0];
   wire fc32      = &div_cnt[4:0];
   wire fc128     = &div_cnt[6:0];
   wire fc2048    = &div_cnt[10:0];
   wire fs8       = low_freq_tick & (&fs_cnt);
   // code 000 falls back to fs/8 in slow or sleep mode, or when prescale_source_select is set
   wire slot0     = (low_power | prescale_source_select) ? fs8 : fc2048;
   wire pin_a_rise = timer_a_pin & ~pin_a_q;
   wire pin_b_rise = timer_b_pin & ~pin_b_q;
   wire [7:0] src_a = {pin_a_rise, 1'b1, fc2, low_freq_tick, fc8, fc32, fc128, slot0};
   wire [7:0] src_b = {pin_b_rise, 1'b1, fc2, low_freq_tick, fc8, fc32, fc128, slot0};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 11'h000;
         fs_cnt  <= 3'h0;
         pin_a_q <= 1'b0;
         pin_b_q <= 1'b0;
      end else if (ce) begin
         div_cnt <= div_cnt + 11'h001;
         fs_cnt  <= low_freq_tick ? fs_cnt + 3'h1 : fs_cnt;
         pin_a_q <= timer_a_pin;
         pin_b_q <= timer_b_pin;
      end
   end

   // ---------------- run control and source selection ----------------
   wire cascade = timer_a_control.mode == timer_pkg::MODE_CASCADE;
   // cascaded pair takes start and preset from the second timer
   wire a_run   = cascade ? timer_b_control.start : timer_a_control.start;
   wire a_flop  = cascade ? timer_b_control.flop_preset : timer_a_control.flop_preset;
   wire b_run   = timer_b_control.start;
   wire a_ok    = ~low_power | timer_pkg::SLOW_CLK_MASK[timer_a_control.clock_select];
   wire b_ok    = ~low_power | timer_pkg::SLOW_CLK_MASK[timer_b_control.clock_select];
   // lower byte of a cascade counts on the first timer's own select
   wire next_a_tick = a_run & a_ok & src_a[timer_a_control.clock_select];
   wire b_upper     = timer_b_control.mode[2];
   wire next_b_tick = b_run & (b_upper ? timer_a_overflow
                                       : (b_ok & src_b[timer_b_control.clock_select]));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_a_tick <= 1'b0;
         timer_b_tick <= 1'b0;
      end else if (ce) begin
         timer_a_tick <= next_a_tick;
         timer_b_tick <= next_b_tick;
      end
   end

   // ---------------- registers ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_a_control <= timer_pkg::CTRL_RESET;
         timer_b_control <= timer_pkg::CTRL_RESET;
         timer_a_period  <= timer_pkg::TREG_RESET;
         timer_a_pulse_width <= timer_pkg::TREG_RESET;
         timer_b_period  <= timer_pkg::TREG_RESET;
         timer_b_pulse_width <= timer_pkg::TREG_RESET;
         prescale_source_select <= 1'b0;
      end else if (wr_en) begin
         // plain storage; run-time write limits are the software's duty
         if (hit_a_ctrl) timer_a_control <= hwdata[7:0];
         if (hit_b_ctrl) timer_b_control <= hwdata[7:0];
         if (hit_a_per)  timer_a_period <= hwdata[7:0];
         if (hit_a_pw)   timer_a_pulse_width <= hwdata[7:0];
         if (hit_b_per)  timer_b_period <= hwdata[7:0];
         if (hit_b_pw)   timer_b_pulse_width <= hwdata[7:0];
         if (hit_config) prescale_source_select <= hwdata[0];
      end
   end

   wire [7:0] status = {2'b00, low_power, ~b_ok, ~a_ok, cascade, b_run, a_run};
   wire [7:0] rd_value = hit_a_ctrl ? timer_a_control :
                         hit_b_ctrl ? timer_b_control :
                         hit_a_per  ? timer_a_period :
                         hit_a_pw   ? timer_a_pulse_width :
                         hit_b_per  ? timer_b_period :
                         hit_b_pw   ? timer_b_pulse_width :
                         hit_config ? {7'h00, prescale_source_select} :
                         hit_status ? status : 8'h00;

   // read data registered during the single wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ce & dp_read) begin
         hrdata <= {24'h000000, rd_value};
      end
   end

   // ---------------- configuration towards the datapath ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_a_cfg <= '0;
         timer_b_cfg <= '0;
      end else if (ce) begin
         timer_a_cfg <= {a_run, a_flop, ~a_run, timer_a_control.mode,
                          timer_a_period, timer_a_pulse_width};
         timer_b_cfg <= {b_run, timer_b_control.flop_preset, ~b_run, timer_b_control.mode,
                          timer_b_period, timer_b_pulse_width};
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_ctrl_reset_zero: assert property (disable iff (1'b0)
      $rose(hresetn) |-> timer_a_control == timer_pkg::CTRL_RESET && !timer_a_cfg.run)
      else $error("control register not zero after reset");
   chk_treg_reset_ones: assert property (disable iff (1'b0)
      $rose(hresetn) |-> timer_a_period == 8'hFF && timer_b_pulse_width == 8'hFF)
      else $error("timer registers not all ones after reset");
   chk_stop_clears: assert property (
      ce && !a_run |=> timer_a_cfg.clear && !timer_a_cfg.run && !timer_a_tick)
      else $error("stopped timer not held clear");
   chk_pin_source_tick: assert property (
      ce && a_run && timer_a_control.clock_select == timer_pkg::CLK_PIN
         && timer_a_pin && !pin_a_q |=> timer_a_tick)
      else $error("pin edge did not give a tick");
   chk_fc_source_tick: assert property (
      ce && a_run && timer_a_control.clock_select == timer_pkg::CLK_FC |=> timer_a_tick)
      else $error("fc source did not tick every cycle");
   chk_slow_code_block: assert property (
      ce && low_power && !timer_pkg::SLOW_CLK_MASK[timer_a_control.clock_select]
         |=> !timer_a_tick)
      else $error("invalid low-power clock code ticked");
   chk_cascade_start_b: assert property (
      ce && cascade |=> timer_a_cfg.run == $past(timer_b_control.start)
         && timer_a_cfg.flop_preset == $past(timer_b_control.flop_preset))
      else $error("cascade not steered by second timer");
   chk_upper_overflow: assert property (
      ce && b_run && b_upper |=> timer_b_tick == $past(timer_a_overflow))
      else $error("upper byte not counting overflow");
   chk_ctrl_readback: assert property (
      ce && dp_write && hit_a_ctrl |=> timer_a_control == $past(hwdata[7:0]))
      else $error("control write not stored");
   chk_read_wait_data: assert property (
      ce && dp_read |=> hreadyout && hrdata == {24'h000000, $past(rd_value)})
      else $error("read answer wrong");
   chk_read_one_wait: assert property (
      ce && dp_read |-> !hreadyout)
      else $error("read data phase not stalled");
   chk_write_no_wait: assert property (
      ce && dp_write |-> hreadyout)
      else $error("write data phase stalled");
   chk_hrdata_stands: assert property (
      ce && !dp_read |=> $stable(hrdata))
      else $error("read data changed without a read");
   chk_b_ctrl_readback: assert property (
      ce && dp_write && hit_b_ctrl |=> timer_b_control == $past(hwdata[7:0]))
      else $error("second control write not stored");
   chk_period_store: assert property (
      ce && dp_write && hit_a_per |=> timer_a_period == $past(hwdata[7:0]))
      else $error("period write not stored");
   chk_ctrl_reset_b: assert property (disable iff (1'b0)
      $rose(hresetn) |-> timer_b_control == timer_pkg::CTRL_RESET && !timer_b_cfg.run)
      else $error("second control register not zero after reset");
   chk_treg_reset_rest: assert property (disable iff (1'b0)
      $rose(hresetn) |-> timer_a_pulse_width == 8'hFF && timer_b_period == 8'hFF)
      else $error("other timer registers not all ones after reset");

   // source clock codes, first timer
   chk_slow_div_tick: assert property (
      ce && a_run && !low_power && !prescale_source_select
         && timer_a_control.clock_select == 3'h0 |=> timer_a_tick == $past(fc2048))
      else $error("code 000 did not follow the long divider");
   chk_fc128_tick: assert property (
      ce && a_run && !low_power && timer_a_control.clock_select == 3'h1
         |=> timer_a_tick == $past(fc128))
      else $error("code 001 wrong tick");
   chk_fc32_tick: assert property (
      ce && a_run && !low_power && timer_a_control.clock_select == 3'h2
         |=> timer_a_tick == $past(fc32))
      else $error("code 010 wrong tick");
   chk_fc8_tick: assert property (
      ce && a_run && !low_power && timer_a_control.clock_select == 3'h3
         |=> timer_a_tick == $past(fc8))
      else $error("code 011 wrong tick");
   chk_fs_tick: assert property (
      ce && a_run && timer_a_control.clock_select == 3'h4
         |=> timer_a_tick == $past(low_freq_tick))
      else $error("code 100 wrong tick");
   chk_fc2_tick: assert property (
      ce && a_run && !low_power && timer_a_control.clock_select == 3'h5
         |=> timer_a_tick == $past(fc2))
      else $error("code 101 wrong tick");

   // second timer, cascade, first-timer start steering and datapath outputs
   chk_slow_code_b: assert property (
      ce && low_power && !b_upper && !timer_pkg::SLOW_CLK_MASK[timer_b_control.clock_select]
         |=> !timer_b_tick)
      else $error("invalid low-power code ticked second timer");
   chk_b_fc_tick: assert property (
      ce && b_run && !b_upper && timer_b_control.clock_select == timer_pkg::CLK_FC
         |=> timer_b_tick)
      else $error("second timer fc source did not tick");
   chk_b_pin_tick: assert property (
      ce && b_run && !b_upper && timer_b_control.clock_select == timer_pkg::CLK_PIN
         && timer_b_pin && !pin_b_q |=> timer_b_tick)
      else $error("second timer pin edge did not tick");
   chk_b_stop_clears: assert property (
      ce && !b_run |=> timer_b_cfg.clear && !timer_b_cfg.run && !timer_b_tick)
      else $error("stopped second timer not held clear");
   chk_upper_no_ovf: assert property (
      ce && b_upper && !timer_a_overflow |=> !timer_b_tick)
      else $error("upper byte ticked without overflow");
   chk_own_start_a: assert property (
      ce && !cascade |=> timer_a_cfg.run == $past(timer_a_control.start)
         && timer_a_cfg.flop_preset == $past(timer_a_control.flop_preset))
      else $error("separate first timer not steered by own bits");
   chk_cascade_fc_src: assert property (
      ce && cascade && a_run && timer_a_control.clock_select == timer_pkg::CLK_FC
         |=> timer_a_tick)
      else $error("cascade not clocked from first select");
   chk_mode_follow: assert property (
      ce |=> timer_a_cfg.mode == $past(timer_a_control.mode)
         && timer_b_cfg.mode == $past(timer_b_control.mode))
      else $error("mode not passed to datapath");
   chk_cfg_regs: assert property (
      ce |=> timer_a_cfg.period == $past(timer_a_period)
         && timer_a_cfg.pulse_width == $past(timer_a_pulse_width))
      else $error("timer registers not passed to datapath");
   chk_b_cfg_regs: assert property (
      ce |=> timer_b_cfg.period == $past(timer_b_period)
         && timer_b_cfg.pulse_width == $past(timer_b_pulse_width))
      else $error("second timer registers not passed to datapath");
   chk_cascade_flag: assert property (
      ce && dp_read && hit_status |=> hrdata[2] == $past(cascade))
      else $error("cascade status wrong");

   cov_cascade_run:  cover property (ce && cascade && a_run ##1 timer_a_tick);
   cov_pin_tick:     cover property (timer_a_control.clock_select == timer_pkg::CLK_PIN
                                     && timer_a_tick);
   cov_upper_tick:   cover property (b_upper && timer_b_tick);
   cov_status_read:  cover property (dp_read && hit_status);
   cov_slow_block:   cover property (low_power && a_run && !a_ok);
endmodule : timer_ctrl

// ---- verification/tb.sv ----
// self-checking bench for the dual timer control block
// assumes one ahb-lite slave whose hreadyout is the bus hready
`timescale 1ns/1ps
module tb;
   logic                  hclk = 0;
   logic                  hresetn = 0;
   logic                  hsel = 0;
   logic [31:0]           haddr = 0;
   logic [1:0]            htrans = 0;
   logic                  hwrite = 0;
   logic [31:0]           hwdata = 0;
   logic [31:0]           hrdata;
   logic                  hready;
   logic [1:0]            pwr = 0;
   logic                  lft = 0;
   logic                  pa = 0;
   logic                  pb = 0;
   logic                  ovf = 0;
   logic                  tk_a;
   logic                  tk_b;
   timer_pkg::timer_cfg_s cfg_a;
   timer_pkg::timer_cfg_s cfg_b;
   logic [7:0]            mdl [8];
   logic [31:0]           rd;
   int                    fails = 0;
   int                    n_checks = 0;
   int                    ca;
   int                    cb;

   always #4 hclk = ~hclk;

   timer_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(), .power_mode(pwr), .low_freq_tick(lft),
      .timer_a_pin(pa), .timer_b_pin(pb), .timer_a_overflow(ovf), .timer_a_tick(tk_a),
      .timer_b_tick(tk_b), .timer_a_cfg(cfg_a), .timer_b_cfg(cfg_b));

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // address phase, then data phase; each ends at an edge with hready high
   task automatic bus(input logic [7:0] idx, input bit wr, input logic [7:0] wd);
      int   k;
      logic r;
      hsel <= 1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      for (int p = 0; p < 2; p++) begin
         k = 0;
         r = 0;
         while (r !== 1) begin
            // value before this edge's updates: hready and hrdata as the slave shows them
            @(posedge hclk);
            r = hready;
            rd = hrdata;
            k++;
            if (k > 50) begin
               fails++;
               conclude();
            end
         end
         if (p == 0) begin
            hsel <= 0;
            htrans <= 2'h0;
            hwdata <= {24'h0, wd};
         end
      end
      if (wr && idx >= 8'h1A && idx <= 8'h20) mdl[idx - 8'h1A] = wd;
   endtask : bus

   task automatic rchk(input logic [7:0] idx);
      bus(idx, 0, 8'h00);
      chk("reg", rd, (idx >= 8'h1A && idx <= 8'h20) ? {24'h0, mdl[idx - 8'h1A]} : 32'h0);
   endtask : rchk

   // counts ticks over 16 cycles; a pending overflow pulse is dropped after one edge
   task automatic cnt;
      ca = 0;
      cb = 0;
      repeat (16) begin
         @(posedge hclk);
         ovf <= 0;
         #1;
         ca += int'(tk_a === 1);
         cb += int'(tk_b === 1);
      end
   endtask : cnt

   // 2048-cycle window with random pin and slow-tick traffic, both timers on code c
   task automatic win(input bit lp, input logic [2:0] c);
      int   na, nb, nl, ra, rb, ea, eb;
      logic va, vb, vl, act;
      na = 0; nb = 0; nl = 0; ra = 0; rb = 0; va = 0; vb = 0; vl = 0;
      repeat (4) @(posedge hclk);
      for (int i = 0; i < 2048; i++) begin
         @(posedge hclk);
         #1;
         na += int'(tk_a === 1);
         nb += int'(tk_b === 1);
         act = (i >= 4 && i < 2040);
         if (act && !va && $urandom_range(0, 1) == 1) begin
            va = 1;
            ra++;
         end else if (!act || $urandom_range(0, 2) == 0) va = 0;
         pa <= va;
         if (act && !vb && $urandom_range(0, 1) == 1) begin
            vb = 1;
            rb++;
         end else if (vb) vb = 0;
         pb <= vb;
         vl = act && !vl && ($urandom_range(0, 3) == 0);
         nl += int'(vl);
         lft <= vl;
      end
      case (c)
         3'h0: ea = 1;
         3'h1: ea = 16;
         3'h2: ea = 64;
         3'h3: ea = 256;
         3'h4: ea = nl;
         3'h5: ea = 1024;
         3'h6: ea = 2048;
         default: ea = ra;
      endcase
      eb = (c == 3'h7) ? rb : ea;
      if (lp && c inside {3'h1, 3'h2, 3'h3, 3'h5}) begin
         ea = 0;
         eb = 0;
      end
      if (!(lp && c == 3'h0)) begin
         chk("ticks_a", na, ea);
         chk("ticks_b", nb, eb);
      end
   endtask : win

   initial begin
      repeat (100000) @(posedge hclk);
      fails++;
      conclude();
   end

   initial begin
      void'($urandom(32'h5c68));
      repeat (10) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      mdl = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
      @(posedge hclk);
      chk("cfg_a_rst", 32'(cfg_a), {10'h0, 6'b001000, 16'hFFFF});
      for (int i = 8'h1A; i < 8'h21; i++) rchk(8'(i));
      bus(8'h30, 1, 8'h5A);
      rchk(8'h30);
      // start bit kept low so every register may be rewritten
      repeat (24) bus(8'($urandom_range(26, 31)), 1, 8'($urandom) & 8'hF7);
      for (int i = 8'h1A; i < 8'h20; i++) rchk(8'(i));
      chk("period_a", cfg_a.period, mdl[2]);
      chk("width_b", cfg_b.pulse_width, mdl[5]);
      bus(8'h1B, 1, 8'h00);
      for (int m = 0; m < 3; m++) begin
         bus(8'h1A, 1, 8'hE8 | 8'(m));
         repeat (2) @(posedge hclk);
         chk("mode", cfg_a.mode, m);
         chk("run", {cfg_a.run, cfg_a.flop_preset, cfg_a.clear}, 3'b110);
         bus(8'h1A, 1, 8'hE0 | 8'(m));
      end
      bus(8'h1A, 1, 8'hE2);
      cnt();
      chk("stop", {cfg_a.run, cfg_a.clear, 6'(ca)}, 8'h40);
      bus(8'h1A, 1, 8'h63);
      bus(8'h1B, 1, 8'h88);
      cnt();
      chk("cascade", {cfg_a.run, cfg_a.flop_preset, cfg_a.mode, 6'(ca)}, 11'h6D0);
      bus(8'h1B, 1, 8'h80);
      repeat (2) @(posedge hclk);
      chk("cascade_stop", cfg_a.run, 1'b0);
      bus(8'h1B, 1, 8'h6C);
      cnt();
      chk("upper_idle", cb, 0);
      ovf <= 1;
      cnt();
      chk("upper_ovf", cb, 1);
      for (int lp = 0; lp < 2; lp++) begin
         pwr <= lp ? 2'h3 : 2'h0;
         for (int c = 0; c < 8; c++) begin
            if (lp == 1 && c == 6) continue;
            bus(8'h1A, 1, mdl[0] & 8'hF7);
            bus(8'h1B, 1, mdl[1] & 8'hF7);
            bus(8'h1A, 1, {1'b0, 3'(c), 4'h8});
            bus(8'h1B, 1, {1'b0, 3'(c), 4'h8});
            win(lp[0], 3'(c));
         end
      end
      conclude();
   end
endmodule : tb
